// ---- rtl/rtcsp_port.sv ----
// Serial slave port of the real-time clock, with register file and watchdog.
// Assumes the host drives chip enable, serial clock and data asynchronously.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Chip enable low resets the whole interface and drops partial transfers.
// - Input bits are captured on rising serial clock edges.
// - Output data changes only on falling edges; released when not reading, and at once on watchdog lock.
// - Bytes are eight bits, most significant bit first.
// - First byte is the command; later bytes are data.
// - Command bit 7 low means write, high means read.
// - Subaddress other than 001 makes the transfer ignored.
// - Command bits 3 to 0 give the starting register index.
// - Index increments after each data byte and wraps to zero.
// - Captured bits move into internal logic on the next falling edge.
// - Time counting is frozen from a valid command byte until the transfer ends.
// - A stuck transfer is cleared by a watchdog, releasing the counters.
// - Watchdog fires between one and two seconds after valid subaddress.
// - Each watchdog expiry loses exactly one second.
// - After a watchdog clear, chip enable must go low before new transfers.
module rtcsp_port #(
   parameter longint WDOG_CYCLES = rtcsp_pkg::WDOG_CYC
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // Serial pins
   input  wire logic       chip_enable,
   input  wire logic       serial_clk,
   input  wire logic       serial_in,
   output logic            serial_out,
   output logic            serial_out_oe,
   // Time counter side
   input  wire logic       second_tick,
   input  wire logic [7:0] time_wr_data,
   input  wire logic [3:0] time_wr_index,
   input  wire logic       time_wr,
   output logic            count_freeze,
   output logic            second_lost,
   output logic            reg_wr,
   output logic [3:0]      reg_wr_index,
   output logic [7:0]      reg_wr_data
);
   logic                     ce_s;
   logic                     sck_s;
   logic                     sdi_s;
   logic                     sck_d;
   logic                     rise;
   logic                     fall;
   logic                     cmd_ok;
   logic [2:0]               bit_cnt;
   logic [7:0]               shift_in;
   logic [7:0]               rx_byte;
   logic                     rx_pend;
   logic                     rx_last;
   logic [7:0]               tx_shift;
   logic                     rd_mode;
   logic [3:0]               index;
   logic [31:0]              wd_cnt;
   logic                     wd_run;
   logic [7:0]               regs [rtcsp_pkg::NUM_REGS];
   rtcsp_pkg::rtcsp_state_t  state;

   function automatic logic [3:0] next_idx(input logic [3:0] i);
      return i + 4'h1;
   endfunction

   function automatic logic sub_ok(input logic [7:0] cmd);
      return cmd[rtcsp_pkg::SUB_HI:rtcsp_pkg::SUB_LO] == rtcsp_pkg::SUBADDR_OK;
   endfunction

   function automatic logic is_read_cmd(input logic [7:0] cmd);
      return sub_ok(cmd) && (cmd[rtcsp_pkg::DIR_BIT] != rtcsp_pkg::DIR_WRITE);
   endfunction

   rtcsp_sync u_ce  (.ref_clk(ref_clk), .srst(srst), .pin(chip_enable), .level(ce_s));
   rtcsp_sync u_sck (.ref_clk(ref_clk), .srst(srst), .pin(serial_clk),  .level(sck_s));
   rtcsp_sync u_sdi (.ref_clk(ref_clk), .srst(srst), .pin(serial_in),   .level(sdi_s));

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection on the filtered serial clock.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sck_d <= 1'h0;
      end else begin
         sck_d <= sck_s;
      end
   end
   assign rise = ce_s & sck_s & ~sck_d;
   assign fall = ce_s & ~sck_s & sck_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Input shifting on rising edges, hand-over on the following falling edge.
   always_ff @(posedge ref_clk) begin
      if (srst || !ce_s) begin
         bit_cnt  <= 3'h0;
         shift_in <= 8'h00;
         rx_pend  <= 1'h0;
         rx_last  <= 1'h0;
         rx_byte  <= 8'h00;
      end else begin
         rx_last <= 1'h0;
         if (rise) begin
            shift_in <= {shift_in[6:0], sdi_s};
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               rx_pend <= 1'h1;
            end
         end else if (fall && rx_pend) begin
            rx_byte <= shift_in;
            rx_pend <= 1'h0;
            rx_last <= 1'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode and transfer state.
   assign cmd_ok = (state == rtcsp_pkg::RTCSP_CMD)
                   && ((fall && rx_pend && sub_ok(shift_in)) || (rx_last && sub_ok(rx_byte)));

   always_ff @(posedge ref_clk) begin
      if (srst || !ce_s) begin
         state   <= rtcsp_pkg::RTCSP_CMD;
         rd_mode <= 1'h0;
         index   <= 4'h0;
      end else if (wd_run && wd_cnt >= 32'(WDOG_CYCLES - 1)) begin
         state <= rtcsp_pkg::RTCSP_LOCKED;
      end else if (rx_last) begin
         case (state)
            rtcsp_pkg::RTCSP_CMD: begin
               if (sub_ok(rx_byte)) begin
                  state   <= rtcsp_pkg::RTCSP_DATA;
                  rd_mode <= rx_byte[rtcsp_pkg::DIR_BIT] != rtcsp_pkg::DIR_WRITE;
                  index   <= rx_byte[3:0];
               end else begin
                  state <= rtcsp_pkg::RTCSP_IGNORE;
               end
            end
            rtcsp_pkg::RTCSP_DATA: begin
               index <= next_idx(index);
            end
            default: begin
               state <= state;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file: written by the port or by the time counters.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < rtcsp_pkg::NUM_REGS; i++) begin
            regs[i] <= rtcsp_pkg::REG_RESET;
         end
         reg_wr       <= 1'h0;
         reg_wr_index <= 4'h0;
         reg_wr_data  <= 8'h00;
      end else begin
         reg_wr <= 1'h0;
         if (rx_last && state == rtcsp_pkg::RTCSP_DATA && !rd_mode) begin
            regs[index]  <= rx_byte;
            reg_wr       <= 1'h1;
            reg_wr_index <= index;
            reg_wr_data  <= rx_byte;
         end else if (time_wr && !count_freeze) begin
            regs[time_wr_index] <= time_wr_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data output, changed on falling edges only.
   always_ff @(posedge ref_clk) begin
      if (srst || !ce_s) begin
         tx_shift      <= 8'h00;
         serial_out    <= 1'h0;
         serial_out_oe <= 1'h0;
      end else if (fall) begin
         if (rx_pend && state == rtcsp_pkg::RTCSP_CMD && is_read_cmd(shift_in)) begin
            tx_shift      <= {regs[shift_in[3:0]][6:0], 1'h0};
            serial_out    <= regs[shift_in[3:0]][7];
            serial_out_oe <= 1'h1;
         end else if (rx_pend && state == rtcsp_pkg::RTCSP_DATA && rd_mode) begin
            tx_shift      <= {regs[next_idx(index)][6:0], 1'h0};
            serial_out    <= regs[next_idx(index)][7];
            serial_out_oe <= 1'h1;
         end else if (state == rtcsp_pkg::RTCSP_DATA && rd_mode) begin
            tx_shift   <= {tx_shift[6:0], 1'h0};
            serial_out <= tx_shift[7];
         end else begin
            serial_out_oe <= 1'h0;
         end
      end else if (state == rtcsp_pkg::RTCSP_LOCKED || state == rtcsp_pkg::RTCSP_IGNORE) begin
         serial_out_oe <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog, counter freeze and the lost second.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wd_cnt       <= 32'h0;
         wd_run       <= 1'h0;
         count_freeze <= 1'h0;
         second_lost  <= 1'h0;
      end else begin
         second_lost  <= 1'h0;
         count_freeze <= ce_s && (state == rtcsp_pkg::RTCSP_DATA || cmd_ok);
         if (!ce_s || state != rtcsp_pkg::RTCSP_DATA) begin
            wd_cnt <= 32'h0;
            wd_run <= 1'h0;
         end else if (wd_cnt >= 32'(WDOG_CYCLES - 1)) begin
            wd_run      <= 1'h0;
            second_lost <= 1'h1;
         end else begin
            wd_run <= 1'h1;
            wd_cnt <= wd_cnt + 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/rtcsp_pkg.sv ----
// Package of constants for the three-line serial port of the clock.
// Assumes a 125 MHz ref_clk; serial pins are asynchronous to it.
package rtcsp_pkg;
   localparam int          CLK_HZ          = 125_000_000;
   localparam int          BYTE_BITS       = 8;
   localparam int          IDX_W           = 4;
   localparam int          NUM_REGS        = 16;
   localparam int          DIR_BIT         = 7;
   localparam int          SUB_HI          = 6;
   localparam int          SUB_LO          = 4;
   localparam logic [2:0]  SUBADDR_OK      = 3'h1;
   localparam logic        DIR_WRITE       = 1'h0;
   localparam int          WDOG_MIN_S      = 1;
   localparam int          WDOG_MAX_S      = 2;
   // Fire halfway between the least and the longest time, in cycles.
   localparam longint      WDOG_CYC        = longint'(CLK_HZ) * 3 / 2;
   localparam logic [7:0]  REG_RESET       = 8'h00;
   typedef enum logic [1:0] {RTCSP_CMD, RTCSP_DATA, RTCSP_IGNORE, RTCSP_LOCKED} rtcsp_state_t;
endpackage

// ---- rtl/rtcsp_sync.sv ----
// Three-flop synchroniser with agreement filter for one pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module rtcsp_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // Pin and filtered level
   input  wire logic pin,
   output logic      level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s1 <= 1'h0;
         s2 <= 1'h0;
         s3 <= 1'h0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // The level changes only once the second and third flops agree.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         level <= 1'h0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule
`default_nettype wire

// ---- dv/rtcsp_sva.sv ----
// Checker for the serial port of the clock.
// Assumes it is bound into rtcsp_port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module rtcsp_chk #(
   parameter longint WDOG_CYCLES = rtcsp_pkg::WDOG_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Serial pins
   input wire logic chip_enable,
   input wire logic serial_clk,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   // Counter side
   input wire logic count_freeze,
   input wire logic second_lost,
   input wire logic reg_wr
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic   sclk_q;
   logic   pend;
   logic   locked;
   longint frz;
   always_ff @(posedge ref_clk) sclk_q <= serial_clk;
   always_ff @(posedge ref_clk) begin
      if (srst) pend <= 1'h0;
      else if (sclk_q && !serial_clk) pend <= 1'h1;
      else if ($changed(serial_out)) pend <= 1'h0;
   end
   always_ff @(posedge ref_clk) begin
      if (srst || (!count_freeze && !$past(count_freeze, 3))) frz <= 0;
      else if (count_freeze) frz <= frz + 1;
   end
   always_ff @(posedge ref_clk) begin
      if (srst || !chip_enable) locked <= 1'h0;
      else if (second_lost) locked <= 1'h1;
   end
   sequence s_expire; second_lost; endsequence
   sequence s_released; !count_freeze [*2]; endsequence
   AST_CE_IDLE: assert property (!chip_enable [*8] |-> !serial_out_oe && !count_freeze)
      else $error("port active with chip enable low");
   AST_OUT_FALL: assert property ($changed(serial_out) && serial_out_oe |-> pend)
      else $error("serial output changed without a clock fall");
   AST_OE_VALID: assert property (serial_out_oe |-> count_freeze)
      else $error("output driven outside a valid transfer");
   AST_WR_VALID: assert property (reg_wr |-> count_freeze)
      else $error("write outside a valid transfer");
   AST_WR_GAP: assert property (reg_wr |=> !reg_wr [*8])
      else $error("writes closer than one byte");
   AST_RELEASE: assert property (s_expire |-> ##[0:2] s_released)
      else $error("counters not released after expiry");
   AST_WDOG_TIME: assert property (second_lost |-> frz >= WDOG_CYCLES - 4 && frz <= WDOG_CYCLES + 4)
      else $error("watchdog expiry at wrong time");
   AST_LOST_ONE: assert property (second_lost |=> !second_lost [*8])
      else $error("more than one second lost");
   AST_LOCKED: assert property (locked && $past(locked, 2) |-> !reg_wr && !count_freeze && !serial_out_oe)
      else $error("port active after watchdog clear");
endmodule
bind rtcsp_port rtcsp_chk #(.WDOG_CYCLES(WDOG_CYCLES)) i_chk (.ref_clk(ref_clk), .srst(srst),
   .chip_enable(chip_enable), .serial_clk(serial_clk), .serial_out(serial_out),
   .serial_out_oe(serial_out_oe), .count_freeze(count_freeze), .second_lost(second_lost),
   .reg_wr(reg_wr));
`default_nettype wire

// ---- dv/rtcsp_host.sv ----
// Serial host model that frames transfers on the three-line port.
// Assumes an 80 ns serial clock period, unrelated to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module rtcsp_host (
   // Serial pins
   output logic      chip_enable,
   output logic      serial_clk,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe
);
   logic [7:0] tx [0:18];
   logic [7:0] rx [0:18];
   logic       seen_oe;
   initial begin
      chip_enable = 1'h0;
      serial_clk = 1'h0;
      serial_in = 1'h0;
   end
   // Shifts nbits of tx out and samples the output before each fall.
   task automatic xfer(input int nbits, input bit hold);
      int i;
      #1;
      seen_oe = 1'h0;
      chip_enable = 1'h1;
      #40;
      for (i = 0; i < nbits; i++) begin
         serial_in = tx[i/8][7-i%8];
         #40 serial_clk = 1'h1;
         #40 rx[i/8][7-i%8] = serial_out_oe ? serial_out : 1'bx;
         seen_oe |= serial_out_oe;
         serial_clk = 1'h0;
      end
      #80 chip_enable = hold;
      serial_in = ~serial_in;
      #200;
   endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Testbench for the serial port of the clock.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam longint WDOG = 2000;
   logic        ref_clk, srst, chip_enable, serial_clk, serial_in, serial_out, serial_out_oe;
   logic        count_freeze, second_lost, reg_wr;
   logic        time_wr;
   logic [3:0]  time_wr_index;
   logic [7:0]  time_wr_data;
   logic [3:0]  reg_wr_index;
   logic [7:0]  reg_wr_data;
   logic [7:0]  mem [0:15];
   logic [11:0] exp_q [$];
   int          fail_count = 0, checked = 0, lost = 0, j;
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   rtcsp_port #(.WDOG_CYCLES(WDOG)) i_dut (.ref_clk(ref_clk), .srst(srst),
      .chip_enable(chip_enable), .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe), .second_tick(1'h0),
      .time_wr_data(time_wr_data), .time_wr_index(time_wr_index), .time_wr(time_wr),
      .count_freeze(count_freeze),
      .second_lost(second_lost), .reg_wr(reg_wr), .reg_wr_index(reg_wr_index),
      .reg_wr_data(reg_wr_data));
   rtcsp_host i_host (.chip_enable(chip_enable), .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] idx_at(input logic [3:0] s, input int k);
      return s + 4'(k);
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] s, input int n, input logic [2:0] sub);
      int k;
      i_host.tx[0] = {1'h0, sub, s};
      for (k = 0; k < n; k++) begin
         i_host.tx[k+1] = 8'($urandom);
         if (sub == rtcsp_pkg::SUBADDR_OK) begin
            mem[idx_at(s, k)] = i_host.tx[k+1];
            exp_q.push_back({idx_at(s, k), i_host.tx[k+1]});
         end
      end
      i_host.xfer(8 * (n + 1), 1'b0);
      chk("pending writes", 32'h0, 32'(exp_q.size()));
   endtask
   task automatic rd(input logic [3:0] s, input int n);
      int k;
      i_host.tx[0] = {1'h1, rtcsp_pkg::SUBADDR_OK, s};
      for (k = 0; k < n; k++) i_host.tx[k+1] = 8'($urandom);
      i_host.xfer(8 * (n + 1), 1'b0);
      for (k = 0; k < n; k++) begin
         chk("read byte", 32'(mem[idx_at(s, k)]), 32'(i_host.rx[k+1]));
      end
   endtask
   // One counter update; it must be dropped while the port holds the counters frozen.
   task automatic tick_wr(input logic [3:0] idx, input logic [7:0] val, input bit frozen);
      @(posedge ref_clk);
      #1 time_wr = 1'h1;
      time_wr_index = idx;
      time_wr_data = val;
      if (!frozen) mem[idx] = val;
      @(posedge ref_clk);
      #1 time_wr = 1'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      if (second_lost === 1'h1) lost++;
      if (reg_wr === 1'h1 && exp_q.size() == 0) chk("unexpected write", 32'h0, 32'h1);
      else if (reg_wr === 1'h1) chk("write", 32'(exp_q.pop_front()), {20'h0, reg_wr_index, reg_wr_data});
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      srst = 1'h1;
      time_wr = 1'h0;
      time_wr_index = 4'h0;
      time_wr_data = 8'h00;
      void'($urandom(32'ha2bb396d));
      for (j = 0; j < 16; j++) mem[j] = rtcsp_pkg::REG_RESET;
      repeat (6) @(posedge ref_clk);
      #1 srst = 1'h0;
      repeat (5) @(posedge ref_clk);
      tick_wr(4'($urandom), {7'($urandom), 1'h1}, 1'b0);
      rd(4'h0, 16);
      for (j = 0; j < 4; j++) wr(4'($urandom), 1 + $urandom % 17, rtcsp_pkg::SUBADDR_OK);
      wr(4'hf, 2, rtcsp_pkg::SUBADDR_OK);
      i_host.tx[0] = 8'h12;
      i_host.xfer(12, 1'b0);
      rd(4'($urandom), 18);
      for (j = 0; j < 8; j++) begin
         if (j != 1) begin
            wr(4'h3, 2, 3'(j));
            i_host.tx[0] = {1'h1, 3'(j), 4'h3};
            i_host.xfer(24, 1'b0);
            chk("driven on bad read", 32'h0, 32'(i_host.seen_oe));
         end
      end
      i_host.tx[0] = 8'h15;
      i_host.xfer(8, 1'b1);
      tick_wr(4'h5, ~mem[5], 1'b1);
      repeat (WDOG + 100) @(posedge ref_clk);
      chk("lost seconds", 32'h1, 32'(lost));
      i_host.tx[0] = 8'h95;
      i_host.xfer(16, 1'b0);
      chk("driven while locked", 32'h0, 32'(i_host.seen_oe));
      rd(4'h0, 16);
      give_verdict();
   end
endmodule
`default_nettype wire
